// ==== bench/asrp_host.sv ====
`timescale 1ns/1ns
module asrp_host (
	output logic o_clk_shift,
	output logic o_convert_start_line,
	input wire logic i_dout,
	input wire logic i_dout_oe
);
	logic [15:0] rx_reg;
	logic [15:0] rx_rise_reg;
	int rx_cnt;
	initial begin
		o_clk_shift = 0;
		o_convert_start_line = 1;
	end
	always @(negedge o_clk_shift) begin
		if (i_dout_oe === 1'b1) begin
			rx_reg <= {rx_reg[14:0], i_dout};
			rx_cnt <= rx_cnt + 1;
		end
	end
	always @(posedge o_clk_shift) begin
		if (i_dout_oe === 1'b1) begin
			rx_rise_reg <= {rx_rise_reg[14:0], i_dout};
		end
	end
	task automatic tick(input int n);
		repeat (n) begin
			#16 o_clk_shift = 1;
			#16 o_clk_shift = 0;
		end
	endtask : tick
	task automatic conv(input int n);
		rx_cnt = 0;
		o_convert_start_line = 0;
		tick(n);
		o_convert_start_line = 1;
		tick(4);
	endtask : conv
	// transmit word drives convert-start, MSB first
	task automatic send(input logic [15:0] w, input int n);
		rx_cnt = 0;
		for (int b = n - 1; b >= 0; b--) begin
			o_convert_start_line = w[b];
			tick(1);
		end
		o_convert_start_line = 1;
		tick(4);
	endtask : send
endmodule : asrp_host

// ==== bench/asrp_port_chk.sv ====
`timescale 1ns/1ns
module asrp_port_chk (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_clk_shift,
	input wire logic i_convert_start_line,
	input wire logic [asrp_pkg::RESULT_WIDTH-1:0] i_sample,
	input wire logic i_shutdown_n,
	input wire logic o_dout,
	input wire logic o_dout_oe,
	input wire logic [1:0] o_power_state,
	input wire logic [asrp_pkg::RESULT_WIDTH-1:0] o_last_result,
	input wire logic o_result_toggle
);
	logic [3:0] oe_cnt_reg;
	logic [3:0] oe_cnt_next;
	always_comb begin
		oe_cnt_next = o_dout_oe ? oe_cnt_reg + 4'h1 : 4'h0;
	end
	always_ff @(posedge i_clk_shift) begin
		oe_cnt_reg <= i_rst_n ? oe_cnt_next : 4'h0;
	end
	sequence lead_s;
		(!o_dout) [*4] ##1 o_dout == i_sample[7];
	endsequence
	sequence tail_s;
		o_dout == i_sample[1] ##1 o_dout == i_sample[0] ##1 !o_dout;
	endsequence
	sequence low_s;
		(!i_convert_start_line) [*8];
	endsequence
	start_low_a:
		assert property (@(posedge i_clk_shift) disable iff (!i_rst_n)
			$rose(o_dout_oe) |-> !o_dout) else $error("line not low at start");
	conv_lat_a:
		assert property (@(posedge i_clk_shift) disable iff (!i_rst_n || !i_shutdown_n)
			$fell(i_convert_start_line) |-> ##3 o_dout_oe) else $error("no frame start");
	msb_time_a:
		assert property (@(posedge i_clk_shift) disable iff (!i_rst_n || !i_shutdown_n)
			$rose(o_dout_oe) |-> lead_s) else $error("bad lead or msb");
	lsb_tail_a:
		assert property (@(posedge i_clk_shift) disable iff (!i_rst_n || !i_shutdown_n)
			$rose(o_dout_oe) ##1 low_s ##1 (!i_convert_start_line) [*2] |-> tail_s)
			else $error("bad low bits");
	release_a:
		assert property (@(posedge i_clk_shift) disable iff (!i_rst_n || !i_shutdown_n)
			$rose(o_dout_oe) ##1 low_s ##1 (!i_convert_start_line) [*4]
			|-> o_dout_oe ##1 !o_dout_oe) else $error("line not released");
	oe_limit_a:
		assert property (@(posedge i_clk_shift) disable iff (!i_rst_n)
			oe_cnt_reg <= 4'hD) else $error("frame too long");
	dout_edge_a:
		assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
			$changed(o_dout) |-> i_clk_shift) else $error("line moved off rise");
	result_a:
		assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
			$changed(o_result_toggle) |-> ##[0:2] o_last_result == i_sample)
			else $error("wrong result");
endmodule : asrp_port_chk
bind asrp_port asrp_port_chk i_asrp_port_chk (.i_clk_sys, .i_rst_n, .i_clk_shift,
	.i_convert_start_line, .i_sample, .i_shutdown_n, .o_dout, .o_dout_oe,
	.o_power_state, .o_last_result, .o_result_toggle);

// ==== bench/tb.sv ====
`timescale 1ns/1ns
module tb;
	logic i_clk_sys;
	logic i_rst_n;
	logic [7:0] i_sample;
	logic i_shutdown_n;
	logic clk_shift;
	logic cs_line;
	logic dout;
	logic dout_oe;
	logic [1:0] pwr;
	logic [7:0] last;
	logic tgl;
	logic old_tgl;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [7:0] vals [3] = '{8'hA5, 8'h80, 8'h01};
	initial begin
		i_clk_sys = 0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	asrp_port i_asrp_port (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_clk_shift(clk_shift),
		.i_convert_start_line(cs_line), .i_sample(i_sample), .i_shutdown_n(i_shutdown_n),
		.o_dout(dout), .o_dout_oe(dout_oe), .o_power_state(pwr), .o_last_result(last),
		.o_result_toggle(tgl));
	asrp_host i_asrp_host (.o_clk_shift(clk_shift), .o_convert_start_line(cs_line),
		.i_dout(dout), .i_dout_oe(dout_oe));
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// syncs into the system domain need a few cycles after the last shift edge
	task automatic frame(input int n);
		old_tgl = tgl;
		i_asrp_host.conv(n);
		repeat (10) @(posedge i_clk_sys);
	endtask : frame
	task automatic frame_word(input logic [15:0] w, input int n);
		old_tgl = tgl;
		i_asrp_host.send(w, n);
		repeat (10) @(posedge i_clk_sys);
	endtask : frame_word
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			end_of_test();
		end
	end
	initial begin
		i_rst_n = 0;
		i_sample = 8'hA5;
		i_shutdown_n = 1;
		i_asrp_host.tick(6);
		@(posedge i_clk_sys) i_rst_n <= 1;
		i_asrp_host.tick(4);
		foreach (vals[k]) begin
			@(posedge i_clk_sys) i_sample <= vals[k];
			frame(16);
			chk("frame", {3'h0, vals[k], 1'b0}, i_asrp_host.rx_reg[11:0]);
			chk("result", {4'h0, vals[k]}, {4'h0, last});
			chk("toggle", {11'h0, ~old_tgl}, {11'h0, tgl});
			chk("state", 12'h0, {10'h0, pwr});
		end
		$display("test single done");
		frame(8);
		chk("state", 12'h1, {10'h0, pwr});
		chk("oe", 12'h0, {11'h0, dout_oe});
		frame(8);
		chk("state", 12'h3, {10'h0, pwr});
		frame(16);
		chk("state", 12'h0, {10'h0, pwr});
		$display("test power done");
		@(posedge i_clk_sys) i_shutdown_n <= 0;
		frame(16);
		chk("state", 12'h3, {10'h0, pwr});
		chk("bits", 12'h0, i_asrp_host.rx_cnt[11:0]);
		@(posedge i_clk_sys) i_shutdown_n <= 1;
		frame(0);
		chk("state", 12'h0, {10'h0, pwr});
		$display("test shutdown done");
		frame_word(16'h00FF, 16);
		chk("state", 12'h1, {10'h0, pwr});
		frame_word(16'h0000, 8);
		chk("state", 12'h3, {10'h0, pwr});
		@(posedge i_clk_sys) i_sample <= 8'h3C;
		frame_word(16'h0001, 16);
		chk("frame", {3'h0, 8'h3C, 1'b0}, i_asrp_host.rx_reg[11:0]);
		chk("rise", {3'h0, 8'h3C, 1'b0}, i_asrp_host.rx_rise_reg[11:0]);
		chk("result", {4'h0, 8'h3C}, {4'h0, last});
		chk("toggle", {11'h0, ~old_tgl}, {11'h0, tgl});
		chk("state", 12'h0, {10'h0, pwr});
		$display("test word done");
		end_of_test();
	end
endmodule : tb

// ==== rtl/asrp_pkg.sv ====
package asrp_pkg;

	// ************************************************************
	// frame layout, counted in shift-clock rising edges
	// ************************************************************
	localparam int unsigned RESULT_WIDTH = 8;
	localparam logic [3:0] EDGE_MSB = 4'h4;
	localparam logic [3:0] EDGE_PD_LO = 4'h4;
	localparam logic [3:0] EDGE_PD_HI = 4'h9;
	localparam logic [3:0] EDGE_LAST_DATA = 4'hB;
	localparam logic [3:0] EDGE_FRAME_END = 4'hC;
	localparam logic [3:0] EDGE_CNT_RESET = 4'h0;
	localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 8'h00;

	// ************************************************************
	// power state after power-up is full power-down
	// ************************************************************
	typedef enum logic [1:0] {
		ASRP_PWR_NORMAL = 2'b00,
		ASRP_PWR_PARTIAL = 2'b01,
		ASRP_PWR_FULL = 2'b11
	} asrp_pwr_type;

	localparam asrp_pwr_type PWR_RESET = ASRP_PWR_FULL;

endpackage : asrp_pkg

// ==== rtl/asrp_port.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// [RL1] host is master and makes shift clock
// [RL2] convert-start falling edge begins a conversion
// [RL3] output goes low when conversion starts
// [RL4] output changes only on shift-clock rising edges
// [RL5] host samples next rising edge, matched modes
// [RL6] host samples next falling edge, mixed modes
// [RL7] byte-wide host does two byte reads
// [RL8] host gives twelve shift clocks per result
// [RL9] frame: three zeros, eight bits MSB first, zero
// [RL10] DSP frame-sync pulse precedes each word
// [RL11] eight-bit word to enter power-down
// [RL12] convert-start idles high during power-down
// [RL13] host sends 0001h continuous, 00FFh power-down
// [RL14] early framing: one-cycle high pulse, last bit
// [RL15] late framing: held low whole conversion
// [RL16] MSB appears at fourth rising edge
// [RL17] back-to-back: raise between edges ten, eleven
// [RL18] early rise enters partial, then full power-down
// [RL19] low at twelfth edge: release output next rise
// [RL20] modes chosen only by convert-start timing; here i_shutdown_n also forces full power-down
module asrp_port (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_clk_shift,
	input wire logic i_convert_start_line,
	input wire logic [asrp_pkg::RESULT_WIDTH-1:0] i_sample,
	input wire logic i_shutdown_n,
	output logic o_dout,
	output logic o_dout_oe,
	output logic [1:0] o_power_state,
	output logic [asrp_pkg::RESULT_WIDTH-1:0] o_last_result,
	output logic o_result_toggle
);

	// ************************************************************
	// link domain: shift clock
	// ************************************************************
	// the link has no reset pin; system reset is brought over by two flops
	logic link_rst_sync;
	asrp_sync #(.WIDTH(1)) u_rst_sync (
		.i_clk(i_clk_shift),
		.i_rst_n(i_rst_n),
		.i_async(1'b1),
		.o_sync(link_rst_sync)
	);

	logic [1:0] cs_sync;
	// the shift clock is free of convert-start; resample the pin and its own past
	logic cs_meta_reg;
	logic cs_meta_next;
	logic cs_lvl_reg;
	logic cs_lvl_next;
	logic cs_prev_reg;
	logic cs_prev_next;
	logic [3:0] edge_cnt_reg;
	logic [3:0] edge_cnt_next;
	logic active_reg;
	logic active_next;
	logic [asrp_pkg::RESULT_WIDTH-1:0] shift_reg;
	logic [asrp_pkg::RESULT_WIDTH-1:0] shift_next;
	logic dout_reg;
	logic dout_next;
	logic oe_reg;
	logic oe_next;
	logic release_pend_reg;
	logic release_pend_next;
	asrp_pkg::asrp_pwr_type pwr_reg;
	asrp_pkg::asrp_pwr_type pwr_next;
	logic [asrp_pkg::RESULT_WIDTH-1:0] held_reg;
	logic [asrp_pkg::RESULT_WIDTH-1:0] held_next;
	logic tog_reg;
	logic tog_next;
	logic shdn_meta_reg;
	logic shdn_lvl_reg;
	logic shdn_prev_reg;

	assign cs_sync = {cs_lvl_reg, cs_prev_reg};

	function automatic logic in_pd_window(input logic [3:0] cnt);
		in_pd_window = (cnt >= asrp_pkg::EDGE_PD_LO) && (cnt < asrp_pkg::EDGE_PD_HI);
	endfunction : in_pd_window

	always_comb begin
		cs_meta_next = i_convert_start_line;
		cs_lvl_next = cs_meta_reg;
		cs_prev_next = cs_lvl_reg;
		edge_cnt_next = edge_cnt_reg;
		active_next = active_reg;
		shift_next = shift_reg;
		dout_next = dout_reg;
		oe_next = oe_reg;
		release_pend_next = release_pend_reg;
		pwr_next = pwr_reg;
		held_next = held_reg;
		tog_next = tog_reg;
		// [RL19] release on the rise after a held-low frame end
		if (release_pend_reg) begin
			oe_next = 1'b0;
			release_pend_next = 1'b0;
		end
		// [RL2] falling convert-start starts a sequence
		if (cs_sync == 2'b01) begin
			active_next = 1'b1;
			edge_cnt_next = asrp_pkg::EDGE_CNT_RESET;
			shift_next = i_sample;
			// [RL3] output driven low as conversion begins
			dout_next = 1'b0;
			oe_next = 1'b1;
			release_pend_next = 1'b0;
		end else if (active_reg) begin
			edge_cnt_next = edge_cnt_reg + 4'h1;
			// [RL9] zeros, data MSB first, trailing zero
			// [RL4] output updated only in this clock domain
			if (edge_cnt_next >= asrp_pkg::EDGE_MSB && edge_cnt_next < asrp_pkg::EDGE_FRAME_END) begin
				dout_next = shift_reg[asrp_pkg::RESULT_WIDTH-1];
				shift_next = {shift_reg[asrp_pkg::RESULT_WIDTH-2:0], 1'b0};
			end else begin
				dout_next = 1'b0;
			end
			// [RL18] early rise of convert-start steps power down
			if (cs_lvl_reg && in_pd_window(edge_cnt_reg)) begin
				active_next = 1'b0;
				oe_next = 1'b0;
				pwr_next = (pwr_reg == asrp_pkg::ASRP_PWR_NORMAL) ?
					asrp_pkg::ASRP_PWR_PARTIAL : asrp_pkg::ASRP_PWR_FULL;
			end else if (cs_lvl_reg && edge_cnt_reg >= asrp_pkg::EDGE_PD_HI) begin
				// a full frame wakes the converter
				pwr_next = asrp_pkg::ASRP_PWR_NORMAL;
			end
			// [RL8] twelfth rising edge ends the frame; i_sample held, toggle flipped
			if (edge_cnt_next == asrp_pkg::EDGE_FRAME_END) begin
				active_next = 1'b0;
				held_next = i_sample;
				tog_next = ~tog_reg;
				pwr_next = asrp_pkg::ASRP_PWR_NORMAL;
				// [RL19] still low at twelfth edge: float next rise
				if (!cs_lvl_reg) begin
					release_pend_next = 1'b1;
				end else begin
					oe_next = 1'b0;
				end
			end
		end
		// [RL20] pin overrides timing-selected modes
		if (!shdn_lvl_reg) begin
			pwr_next = asrp_pkg::ASRP_PWR_FULL;
			active_next = 1'b0;
			oe_next = 1'b0;
		end else if (!shdn_prev_reg) begin
			// leaving shutdown always lands in normal mode, whatever came before
			pwr_next = asrp_pkg::ASRP_PWR_NORMAL;
		end
	end

	always_ff @(posedge i_clk_shift) begin
		if (!link_rst_sync) begin
			// reset as released so that no false exit from shutdown follows reset
			shdn_meta_reg <= 1'b1;
			shdn_lvl_reg <= 1'b1;
			shdn_prev_reg <= 1'b1;
			cs_meta_reg <= 1'b1;
			cs_lvl_reg <= 1'b1;
			cs_prev_reg <= 1'b1;
			edge_cnt_reg <= asrp_pkg::EDGE_CNT_RESET;
			active_reg <= 1'b0;
			shift_reg <= asrp_pkg::RESULT_RESET;
			dout_reg <= 1'b0;
			oe_reg <= 1'b0;
			release_pend_reg <= 1'b0;
			pwr_reg <= asrp_pkg::PWR_RESET;
			held_reg <= asrp_pkg::RESULT_RESET;
			tog_reg <= 1'b0;
		end else begin
			cs_meta_reg <= cs_meta_next;
			cs_lvl_reg <= cs_lvl_next;
			cs_prev_reg <= cs_prev_next;
			shdn_meta_reg <= i_shutdown_n;
			shdn_lvl_reg <= shdn_meta_reg;
			shdn_prev_reg <= shdn_lvl_reg;
			edge_cnt_reg <= edge_cnt_next;
			active_reg <= active_next;
			shift_reg <= shift_next;
			dout_reg <= dout_next;
			oe_reg <= oe_next;
			release_pend_reg <= release_pend_next;
			pwr_reg <= pwr_next;
			held_reg <= held_next;
			tog_reg <= tog_next;
		end
	end

	assign o_dout = dout_reg;
	assign o_dout_oe = oe_reg;

	// ************************************************************
	// system domain: status crossing
	// ************************************************************
	// power state changes one bit at a time except full to normal and normal to full, where a two-flop sync can see a false code
	logic [1:0] pwr_sys;
	logic tog_sys;
	asrp_sync #(.WIDTH(3)) u_stat_sync (
		.i_clk(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_async({pwr_reg, tog_reg}),
		.o_sync({pwr_sys, tog_sys})
	);

	logic tog_d_reg;
	logic tog_d_next;
	logic [asrp_pkg::RESULT_WIDTH-1:0] last_reg;
	logic [asrp_pkg::RESULT_WIDTH-1:0] last_next;

	// held_reg is stable for a whole frame after the toggle, so word capture is safe
	always_comb begin
		tog_d_next = tog_sys;
		last_next = last_reg;
		if (tog_sys != tog_d_reg) begin
			last_next = held_reg;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			tog_d_reg <= 1'b0;
			last_reg <= asrp_pkg::RESULT_RESET;
		end else begin
			tog_d_reg <= tog_d_next;
			last_reg <= last_next;
		end
	end

	assign o_power_state = pwr_sys;
	assign o_last_result = last_reg;
	assign o_result_toggle = tog_d_reg;

endmodule : asrp_port

// ==== rtl/asrp_sync.sv ====
`timescale 1ns/1ns
// ************************************************************
// two-flop synchroniser for a vector of levels
// ************************************************************
module asrp_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	always_comb begin
		meta_next = i_async;
		sync_next = meta_reg;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign o_sync = sync_reg;

endmodule : asrp_sync
